// ### src/fscp_map.vh
/*
 * Constants of the fanout serial configuration port: register indices,
 * field positions, reset values and frame layout.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef FSCP_MAP_VH
`define FSCP_MAP_VH

// ****************************************
// Frame layout
// ****************************************
`define FSCP_FRAME_BITS      5'h10
`define FSCP_DATA_BITS       4'h9
`define FSCP_CHIP_ADDR       3'h1

// ****************************************
// Register indices
// ****************************************
`define FSCP_REG_READ_SEL    4'h0
`define FSCP_REG_GLOBAL_EN   4'h1
`define FSCP_REG_OUT_EN      4'h2
`define FSCP_REG_RX_CFG      4'h3
`define FSCP_REG_RF_GAIN     4'h4
`define FSCP_REG_BIAS        4'h5

// ****************************************
// Field positions
// ****************************************
`define FSCP_SOFT_RESET_BIT  4
`define FSCP_GLOBAL_EN_BIT   0
`define FSCP_BIAS_SEL_BIT    1
`define FSCP_RX_TERM_BIT     2
`define FSCP_ZIN50_BIT       3
`define FSCP_RF_TOGGLE_BIT   4

// ****************************************
// Reset values
// ****************************************
`define FSCP_RST_READ_SEL    9'h000
`define FSCP_RST_GLOBAL_EN   9'h001
`define FSCP_RST_OUT_EN      9'h0FF
`define FSCP_RST_RX_CFG      9'h00A
`define FSCP_RST_RF_GAIN     9'h007
`define FSCP_RST_BIAS        9'h03A

`endif

// ### src/fscp_port.v
/*
 * Serial configuration port of a clock fanout buffer: shift register,
 * strobe commit, register bank, readback shifter and decoded controls.
 * Assumes shift clock, data-in, strobe and pins are asynchronous to
 * clock; shift clock is far slower than clock so edges are found by
 * sampling. Serial control holds only while control_mode_pin is low.
 */
// Notes on behaviour
// - Device samples data-in on the first nine rising shift-clock edges.
// - Device captures register address on rising edges ten to thirteen.
// - Device captures chip address on rising edges fourteen to sixteen.
// - Strobe rising edge commits data to addressed register if chip matched.
// - Device shifts in sixteen bits while shifting out the selected register.
// - Data-out is released when received chip address is not ours.
// - Low four bits of register zero pick the register shifted out.
// - Writing one to register zero bit four restores all defaults.
// - Reading register zero returns a fixed nine-bit identity word.
// - Register one bit zero is global enable, resets to one.
// - Register two bits zero to seven enable the eight outputs, reset one.
// - Register three holds bias select, rx termination and input impedance.
// - Register three bit four XORs with the RF enable pin.
// - Register four three-bit code sets RF level, resets to seven.
// - Data-out carries the selected register, writes included, while the last whole frame matched and control_mode_pin is low.
`timescale 1ns/10ps
`include "fscp_map.vh"

module fscp_port #(
    parameter [8:0] IDENTITY_WORD = 9'h0A5 // Arbitrary neutral value
)(
    input  wire        clock,
    input  wire        arst_n,
    input  wire        clk_en,
    input  wire        shift_clk,
    input  wire        serial_in_line,
    input  wire        frame_strobe,
    input  wire        control_mode_pin,
    input  wire        rf_output_enable_pin,
    output reg         serial_out_line,
    output reg         serial_out_oe,
    output reg         chip_active,
    output reg  [7:0]  output_enable_bus,
    output reg         internal_bias_select,
    output reg         internal_rx_termination,
    output reg         input_term_50,
    output reg         rf_output_on,
    output reg  [2:0]  rf_level_code
);

    // ****************************************
    // Readback source select
    // ****************************************
    function [8:0] read_mux;
        input [3:0] idx;
        input [8:0] r1;
        input [8:0] r2;
        input [8:0] r3;
        input [8:0] r4;
        input [8:0] r5;
        begin
            case (idx)
                `FSCP_REG_READ_SEL:  read_mux = IDENTITY_WORD;
                `FSCP_REG_GLOBAL_EN: read_mux = r1;
                `FSCP_REG_OUT_EN:    read_mux = r2;
                `FSCP_REG_RX_CFG:    read_mux = r3;
                `FSCP_REG_RF_GAIN:   read_mux = r4;
                `FSCP_REG_BIAS:      read_mux = r5;
                default:             read_mux = 9'h000;
            endcase
        end
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Bit order: shift clock, data, strobe, mode pin, rf pin
    wire [4:0] async_in;
    reg  [4:0] sync1_r;
    reg  [4:0] sync2_r;
    reg  [4:0] prev_r;

    assign async_in = {shift_clk, serial_in_line, frame_strobe, control_mode_pin,
                       rf_output_enable_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_sync
            always @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    prev_r[gi]  <= 1'b0;
                end
                else if (clk_en)
                begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    prev_r[gi]  <= sync2_r[gi];
                end
            end
        end
    endgenerate

    wire sck_s    = sync2_r[4];
    wire din_s    = sync2_r[3];
    wire stb_s    = sync2_r[2];
    wire mode_s   = sync2_r[1];
    wire rfpin_s  = sync2_r[0];
    wire sck_rise = sck_s & ~prev_r[4];
    wire stb_rise = stb_s & ~prev_r[2];
    wire serial_on = ~mode_s;

    // ****************************************
    // Frame shifter and register bank
    // ****************************************
    reg  [15:0] shift_r;
    reg  [4:0]  bit_cnt_r;
    reg  [8:0]  out_shift_r;
    reg         addr_ok_r;
    reg  [8:0]  reg0_r;
    reg  [8:0]  reg1_r;
    reg  [8:0]  reg2_r;
    reg  [8:0]  reg3_r;
    reg  [8:0]  reg4_r;
    reg  [8:0]  reg5_r;

    wire [8:0]  frame_data = shift_r[15:7];
    wire [3:0]  frame_reg  = shift_r[6:3];
    wire [2:0]  frame_chip = shift_r[2:0];
    wire [8:0]  sel_word   = read_mux(reg0_r[3:0], reg1_r, reg2_r, reg3_r,
                                      reg4_r, reg5_r);
    wire        shift_now  = sck_rise & serial_on & ~stb_s;
    // Soft reset is a single commit; no bit of it remains stored
    wire        do_commit  = stb_rise & serial_on & (frame_chip == `FSCP_CHIP_ADDR);
    wire        soft_rst   = do_commit & (frame_reg == `FSCP_REG_READ_SEL) &
                             frame_data[`FSCP_SOFT_RESET_BIT];

    // ****************************************
    // Frame shift register and bit counter
    // ****************************************
    // Data, reg and chip fields fall in place, MSB first
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            shift_r <= 16'h0000;
        else if (clk_en && shift_now)
            shift_r <= {shift_r[14:0], din_s};
    end

    // Saturates at sixteen so an overlong frame still counts as whole
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            bit_cnt_r <= 5'h00;
        else if (clk_en)
        begin
            if (stb_rise)
                bit_cnt_r <= 5'h00;
            else if (shift_now && bit_cnt_r != `FSCP_FRAME_BITS)
                bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // Only a frame seen whole updates the match flag
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            addr_ok_r <= 1'b1;
        else if (clk_en && stb_rise && bit_cnt_r == `FSCP_FRAME_BITS)
            addr_ok_r <= (frame_chip == `FSCP_CHIP_ADDR);
    end

    // Reload only between shifts; a reload on the first rise would repeat bit eight
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            out_shift_r <= 9'h000;
        else if (clk_en)
        begin
            if (shift_now)
                out_shift_r <= {out_shift_r[7:0], 1'b0};
            else if (stb_s || bit_cnt_r == 5'h00)
                out_shift_r <= sel_word;
        end
    end

    // ****************************************
    // Register bank
    // ****************************************
    function reg_hit;
        input [3:0] idx;
        input [3:0] target;
        input       commit;
        begin
            reg_hit = commit & (idx == target);
        end
    endfunction

    // Read select; the soft-reset bit is never stored
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg0_r <= `FSCP_RST_READ_SEL;
        else if (clk_en)
        begin
            if (soft_rst)
                reg0_r <= `FSCP_RST_READ_SEL;
            else if (reg_hit(frame_reg, `FSCP_REG_READ_SEL, do_commit))
                reg0_r <= frame_data;
        end
    end

    // Global enable
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg1_r <= `FSCP_RST_GLOBAL_EN;
        else if (clk_en)
        begin
            if (soft_rst)
                reg1_r <= `FSCP_RST_GLOBAL_EN;
            else if (reg_hit(frame_reg, `FSCP_REG_GLOBAL_EN, do_commit))
                reg1_r <= frame_data;
        end
    end

    // Output buffer enables
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg2_r <= `FSCP_RST_OUT_EN;
        else if (clk_en)
        begin
            if (soft_rst)
                reg2_r <= `FSCP_RST_OUT_EN;
            else if (reg_hit(frame_reg, `FSCP_REG_OUT_EN, do_commit))
                reg2_r <= frame_data;
        end
    end

    // Receiver configuration; reserved bits are stored but drive nothing
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg3_r <= `FSCP_RST_RX_CFG;
        else if (clk_en)
        begin
            if (soft_rst)
                reg3_r <= `FSCP_RST_RX_CFG;
            else if (reg_hit(frame_reg, `FSCP_REG_RX_CFG, do_commit))
                reg3_r <= frame_data;
        end
    end

    // RF gain code
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg4_r <= `FSCP_RST_RF_GAIN;
        else if (clk_en)
        begin
            if (soft_rst)
                reg4_r <= `FSCP_RST_RF_GAIN;
            else if (reg_hit(frame_reg, `FSCP_REG_RF_GAIN, do_commit))
                reg4_r <= frame_data;
        end
    end

    // Bias word: reserved, kept only for readback
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg5_r <= `FSCP_RST_BIAS;
        else if (clk_en)
        begin
            if (soft_rst)
                reg5_r <= `FSCP_RST_BIAS;
            else if (reg_hit(frame_reg, `FSCP_REG_BIAS, do_commit))
                reg5_r <= frame_data;
        end
    end

    // ****************************************
    // Serial output pins
    // ****************************************
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            serial_out_line <= 1'b0;
            serial_out_oe   <= 1'b0;
        end
        else if (clk_en)
        begin
            serial_out_line <= out_shift_r[8];
            serial_out_oe   <= addr_ok_r & serial_on;
        end
    end

    // ****************************************
    // Decoded controls
    // ****************************************
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chip_active             <= 1'b1;
            output_enable_bus       <= 8'hFF;
            internal_bias_select    <= 1'b1;
            internal_rx_termination <= 1'b0;
            input_term_50           <= 1'b1;
            rf_output_on            <= 1'b0;
            rf_level_code           <= 3'h7;
        end
        else if (clk_en)
        begin
            chip_active             <= reg1_r[`FSCP_GLOBAL_EN_BIT];
            output_enable_bus       <= reg2_r[7:0];
            internal_bias_select    <= reg3_r[`FSCP_BIAS_SEL_BIT];
            internal_rx_termination <= reg3_r[`FSCP_RX_TERM_BIT];
            input_term_50           <= reg3_r[`FSCP_ZIN50_BIT];
            // Code zero turns the RF stage off regardless of the pin
            rf_output_on            <= (reg3_r[`FSCP_RF_TOGGLE_BIT] ^ rfpin_s) &
                                       (reg4_r[2:0] != 3'h0);
            rf_level_code           <= reg4_r[2:0];
        end
    end

endmodule

// ### sim/fscp_port_checker.sv
/* Checker of the config port pins, bound to fscp_port.
   Assumes one clock domain and the bench strobe held 8 clocks. */
`timescale 1ns/10ps
// ********
// Checks
// ********
module fscp_port_checker (
    input logic       clock,
    input logic       arst_n,
    input logic       clk_en,
    input logic       frame_strobe,
    input logic       control_mode_pin,
    input logic       serial_out_oe,
    input logic       chip_active,
    input logic [7:0] output_enable_bus,
    input logic       rf_output_on,
    input logic [2:0] rf_level_code
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    reset_vals_a: assert property ($rose(arst_n) |-> chip_active
        && output_enable_bus == 8'hFF && rf_level_code == 3'h7) else $error("bad reset");
    rf_off_a: assert property ((rf_level_code == 3'h0) [*2] |-> !rf_output_on)
        else $error("rf on at code 0");
    mode_oe_a: assert property (control_mode_pin [*5] |-> !serial_out_oe)
        else $error("oe in pin mode");
    mode_hold_a: assert property (control_mode_pin [*8] |-> $stable(output_enable_bus))
        else $error("commit in pin mode");
    no_strobe_a: assert property (!frame_strobe [*8] |->
        $stable({chip_active, output_enable_bus, rf_level_code})) else $error("no strobe");
    gain_cause_a: assert property ($changed(rf_level_code) |->
        $past(frame_strobe, 2) || $past(frame_strobe, 6)) else $error("gain w/o strobe");
    oe_rise_a: assert property ($rose(serial_out_oe) |-> !$past(control_mode_pin, 2))
        else $error("oe rose in pin mode");
    freeze_a: assert property (!clk_en [*2] |-> $stable(serial_out_oe)
        && $stable(chip_active)) else $error("moved while frozen");
    cover property ($rose(frame_strobe));
    cover property ($fell(serial_out_oe));
    cover property ($rose(rf_output_on));
endmodule
bind fscp_port fscp_port_checker chk (.*);

// ### sim/fscp_host.sv
/* Host model: serial master shifting 16-bit frames then strobing.
   Assumes the bench clock; released data-out reads as pulled low. */
`timescale 1ns/10ps
// ********
// Host
// ********
module fscp_host (
    input  logic clock,
    input  logic so_line,
    output logic sck,
    output logic si_line,
    output logic stb
);
    initial
    begin
        sck = 1'b0;
        si_line = 1'b0;
        stb = 1'b0;
    end
    // Shift clock idles low, 125 ns period
    task automatic frame(input logic [15:0] w, output logic [15:0] rd);
        for (int i = 15; i >= 0; i--)
        begin
            si_line <= w[i];
            sck <= 1'b0;
            repeat (12) @(posedge clock);
            rd[i] = so_line;
            sck <= 1'b1;
            repeat (13) @(posedge clock);
        end
        sck <= 1'b0;
        si_line <= ~w[0];
        repeat (2) @(posedge clock);
        stb <= 1'b1;
        repeat (8) @(posedge clock);
        stb <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ### sim/fscp_port_tb.sv
/* Bench of the config port: table of writes and readbacks, then
   hand tests. Assumes the host model and the bound checker. */
`timescale 1ns/10ps
`include "fscp_map.vh"
// ********
// Bench
// ********
module fscp_port_tb;
    localparam logic [8:0] ID = 9'h0C3; // Arbitrary value
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        mode = 1'b0;
    logic        pin = 1'b0;
    logic        so, oe, ca, bs, rx, tf, rfon, sck, si, stb;
    logic [7:0]  ob;
    logic [2:0]  code;
    logic [8:0]  m [0:5];
    logic [15:0] x;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [13:0] rows [15] = '{14'h0200, 14'h0201, 14'h0455, 14'h04AA, 14'h061E, 14'h261E,
        14'h2610, 14'h2800, 14'h0801, 14'h0802, 14'h0803, 14'h0804, 14'h0805, 14'h0806,
        14'h0807};
    always #2.5 clock = ~clock;
    fscp_port #(.IDENTITY_WORD(ID)) dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
        .shift_clk(sck), .serial_in_line(si), .frame_strobe(stb), .control_mode_pin(mode),
        .rf_output_enable_pin(pin), .serial_out_line(so), .serial_out_oe(oe),
        .chip_active(ca), .output_enable_bus(ob), .internal_bias_select(bs),
        .internal_rx_termination(rx), .input_term_50(tf), .rf_output_on(rfon),
        .rf_level_code(code));
    fscp_host host (.clock(clock), .so_line(oe ? so : 1'b0), .sck(sck), .si_line(si),
        .stb(stb));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic defaults();
        m = '{`FSCP_RST_READ_SEL, `FSCP_RST_GLOBAL_EN, `FSCP_RST_OUT_EN,
              `FSCP_RST_RX_CFG, `FSCP_RST_RF_GAIN, `FSCP_RST_BIAS};
    endtask
    task automatic wr(input logic [3:0] idx, input logic [8:0] d, input logic [2:0] adr);
        host.frame({d, idx, adr}, x);
        if (adr == 3'h1 && idx == 4'h0 && d[4])
            defaults();
        else if (adr == 3'h1 && idx < 4'h6)
            m[idx] = d;
    endtask
    task automatic rd(input logic [3:0] idx);
        wr(4'h0, {5'h00, idx}, 3'h1);
        host.frame({5'h00, idx, 4'h0, 3'h1}, x);
        chk(x, {idx == 4'h0 ? ID : idx < 4'h6 ? m[idx] : 9'h000, 7'h00});
    endtask
    task automatic outs();
        chk({ca, ob, bs, rx, tf, rfon, code}, {m[1][0], m[2][7:0], m[3][1],
            m[3][2], m[3][3], (m[3][4] ^ pin) & (m[4][2:0] != 3'h0), m[4][2:0]});
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Ceiling well above the ~28000 cycles of the run
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            finish_test();
        end
    end
    initial
    begin
        defaults();
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (8) @(posedge clock);
        outs();
        for (int i = 0; i < 6; i++)
            rd(4'(i));
        foreach (rows[i])
        begin
            pin <= rows[i][13];
            wr(rows[i][12:9], rows[i][8:0], 3'h1);
            outs();
            rd(rows[i][12:9]);
        end
        wr(4'h2, 9'h00F, 3'h2);
        outs();
        chk(oe, 1'b0);
        rd(4'h9);
        mode <= 1'b1;
        repeat (8) @(posedge clock);
        host.frame({9'h000, 4'h1, 3'h1}, x);
        outs();
        chk(oe, 1'b0);
        mode <= 1'b0;
        clk_en <= 1'b0;
        repeat (8) @(posedge clock);
        clk_en <= 1'b1;
        repeat (8) @(posedge clock);
        wr(4'h0, 9'h010, 3'h1);
        outs();
        rd(4'h5);
        rd(4'h0);
        finish_test();
    end
endmodule
